// ---- design/qhbp_dev.sv ----
// device end: decodes host cycles into the per-channel register file
`timescale 1ns/10ps
module qhbp_dev (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host bus pins
  qhbp_bus_if.dev bus,
  // channel interrupt requests from the uart cores
  input wire logic [qhbp_pkg::NUM_CHAN-1:0] chan_irq,
  // write notice toward the uart cores
  output logic wr_pulse,
  output logic [1:0] wr_chan,
  output logic [qhbp_pkg::ADDR_W-1:0] wr_addr,
  output logic [qhbp_pkg::DATA_W-1:0] wr_data
);
  import qhbp_pkg::*;

  // flat register index from channel and address
  function automatic logic [4:0] reg_index(input logic [1:0] ch,
                                            input logic [2:0] a);
    reg_index = {ch, a};
  endfunction

  // state and captured access
  qhbp_dev_state_t state_reg, state_next;
  logic [1:0] chan_reg, chan_next;         // channel of this access
  logic [2:0] addr_reg, addr_next;         // register of this access
  logic [7:0] rd_data_reg, rd_data_next;   // byte driven on reads
  logic oe_reg, oe_next;                   // data bus drive enable
  // register file, four channels of eight bytes
  logic [7:0] regs_reg [NUM_CHAN*NUM_REG];
  logic [7:0] regs_next [NUM_CHAN*NUM_REG];
  // write notice
  logic wr_pulse_reg, wr_pulse_next;
  logic [1:0] wr_chan_reg, wr_chan_next;
  logic [2:0] wr_addr_reg, wr_addr_next;
  logic [7:0] wr_data_reg, wr_data_next;
  // interrupt pins
  logic int_a_reg, int_a_next;
  logic [3:1] int_bcd_reg, int_bcd_next;
  logic [3:0] irq_oe_reg, irq_oe_next;

  // decoded pin view
  logic strobe_mode;       // high: separate strobes and selects
  logic [3:0] sel;         // active-high channel selects
  logic any_sel;           // some channel selected
  logic [1:0] sel_chan;    // channel targeted by this access
  logic rd_active;         // read cycle in progress on the pins
  logic wr_active;         // write cycle in progress on the pins

  // pin decode for both bus styles
  always_comb begin
    strobe_mode = bus.bus_mode;
    sel = 4'h0;
    sel_chan = 2'h0;
    if (strobe_mode) begin
      // one select pin per channel
      sel = {!bus.chan_d_select_n, !bus.chan_c_select_n,
             !bus.chan_b_select_n, !bus.chan_a_select_n};
      // lowest selected channel wins if host selects several
      if (sel[0]) begin
        sel_chan = 2'h0;
      end else if (sel[1]) begin
        sel_chan = 2'h1;
      end else if (sel[2]) begin
        sel_chan = 2'h2;
      end else begin
        sel_chan = 2'h3;
      end
    end else begin
      // single select, A4/A3 pick channel, D select unused
      sel = {3'h0, !bus.chan_a_select_n};
      sel_chan = {bus.chan_c_select_n, bus.chan_b_select_n};
    end
    any_sel = |sel;
    if (strobe_mode) begin
      // strobes qualify the access
      rd_active = any_sel && !bus.read_strobe_n;
      wr_active = any_sel && !bus.write_strobe_n;
    end else begin
      // read strobe ignored, write strobe is direction
      rd_active = any_sel && bus.write_strobe_n;
      wr_active = any_sel && !bus.write_strobe_n;
    end
  end

  // access sequencing and register file next values
  always_comb begin
    state_next = state_reg;
    chan_next = chan_reg;
    addr_next = addr_reg;
    rd_data_next = rd_data_reg;
    oe_next = 1'b0;
    regs_next = regs_reg;
    wr_pulse_next = 1'b0;
    wr_chan_next = wr_chan_reg;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    case (state_reg)
      QHBP_DEV_IDLE: begin
        if (rd_active) begin
          // falling edge: fetch the addressed byte
          state_next = QHBP_DEV_READ;
          chan_next = sel_chan;
          addr_next = bus.addr;
          rd_data_next = regs_reg[reg_index(sel_chan, bus.addr)];
          oe_next = 1'b1;
        end else if (wr_active) begin
          // falling edge: remember target, data comes at release
          state_next = QHBP_DEV_WRITE;
          chan_next = sel_chan;
          addr_next = bus.addr;
        end
      end
      QHBP_DEV_READ: begin
        // keep driving until strobe or select goes away
        if (rd_active) begin
          oe_next = 1'b1;
        end else begin
          state_next = QHBP_DEV_IDLE;
        end
      end
      QHBP_DEV_WRITE: begin
        if (!wr_active) begin
          // rising edge: latch the byte the host still holds
          state_next = QHBP_DEV_IDLE;
          regs_next[reg_index(chan_reg, addr_reg)] = bus.data_bus;
          wr_pulse_next = 1'b1;
          wr_chan_next = chan_reg;
          wr_addr_next = addr_reg;
          wr_data_next = bus.data_bus;
        end
      end
      default: begin
        state_next = QHBP_DEV_IDLE;
      end
    endcase
  end

  // interrupt pin behaviour per bus style
  always_comb begin
    int_a_next = 1'b0;
    int_bcd_next = 3'h0;
    irq_oe_next = 4'h0;
    if (strobe_mode) begin
      // each pin follows its channel, enabled by modem control bit 3
      int_a_next = chan_irq[0];
      int_bcd_next = chan_irq[3:1];
      for (int c = 0; c < NUM_CHAN; c++) begin
        irq_oe_next[c] = regs_reg[reg_index(c[1:0], MODEM_CTRL_OFS)]
                                 [MODEM_CTRL_IRQ_EN_BIT];
      end
    end else begin
      // shared open drain: pull low while any channel requests
      int_a_next = 1'b0;
      irq_oe_next[0] = |chan_irq;
      // unused pins driven constantly low
      int_bcd_next = 3'h0;
      irq_oe_next[3:1] = 3'h7;
    end
  end

  // register all state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= QHBP_DEV_IDLE;
      chan_reg <= 2'h0;
      addr_reg <= 3'h0;
      rd_data_reg <= 8'h00;
      oe_reg <= 1'b0;
      for (int i = 0; i < NUM_CHAN*NUM_REG; i++) begin
        regs_reg[i] <= REG_RESET;
      end
      wr_pulse_reg <= 1'b0;
      wr_chan_reg <= 2'h0;
      wr_addr_reg <= 3'h0;
      wr_data_reg <= 8'h00;
      int_a_reg <= 1'b0;
      int_bcd_reg <= 3'h0;
      irq_oe_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      chan_reg <= chan_next;
      addr_reg <= addr_next;
      rd_data_reg <= rd_data_next;
      oe_reg <= oe_next;
      regs_reg <= regs_next;
      wr_pulse_reg <= wr_pulse_next;
      wr_chan_reg <= wr_chan_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
      int_a_reg <= int_a_next;
      int_bcd_reg <= int_bcd_next;
      irq_oe_reg <= irq_oe_next;
    end
  end

  // pin and user outputs from flops
  assign bus.dev_data = rd_data_reg;
  assign bus.dev_data_oe = oe_reg;
  assign bus.chan_a_interrupt = int_a_reg;
  assign bus.chan_bcd_interrupt = int_bcd_reg;
  assign bus.irq_oe = irq_oe_reg;
  assign wr_pulse = wr_pulse_reg;
  assign wr_chan = wr_chan_reg;
  assign wr_addr = wr_addr_reg;
  assign wr_data = wr_data_reg;
endmodule // qhbp_dev

// ---- design/qhbp_pkg.sv ----
// constants and types shared by both ends of the host bus port
// How it works
// - mode pin high strobes, low read/write line
// - read strobe fall reads register, rise captures
// - write strobe rise latches held data
// - read strobe ignored in read/write-line mode
// - write strobe becomes direction: high read
// - strobe mode: one select per channel
// - read/write-line mode: channel A select only
// - selects B,C become A3,A4; D ignored
// - strobe mode: channel A irq driven by bit3
// - read/write-line mode: shared open-drain irq
// - channels B-D irq follow bit3 too
// - read/write-line mode: B-D irq held low
package qhbp_pkg;
  localparam int NUM_CHAN = 4;          // channel count
  localparam int ADDR_W = 3;            // register address width
  localparam int DATA_W = 8;            // byte bus
  localparam int NUM_REG = 8;           // registers per channel
  // offset and field of the modem control register
  localparam logic [2:0] MODEM_CTRL_OFS = 3'h4;
  localparam int MODEM_CTRL_IRQ_EN_BIT = 3;
  localparam logic [7:0] REG_RESET = 8'h00;   // every register after reset
  // host strobe timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETUP_NS = 50;         // address before strobe, least
  localparam int STROBE_NS = 150;       // strobe low width, least
  localparam int HOLD_NS = 50;          // data after strobe, least
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 3;             // width of host timing counter
  // device access state
  typedef enum logic [1:0] {
    QHBP_DEV_IDLE = 2'b00,
    QHBP_DEV_READ = 2'b01,
    QHBP_DEV_WRITE = 2'b10
  } qhbp_dev_state_t;
  // host cycle state
  typedef enum logic [1:0] {
    QHBP_HST_IDLE = 2'b00,
    QHBP_HST_SETUP = 2'b01,
    QHBP_HST_STROBE = 2'b11,
    QHBP_HST_HOLD = 2'b10
  } qhbp_hst_state_t;
endpackage

// ---- design/qhbp_bus_if.sv ----
// pin bundle between the host and the quad uart bus port
`timescale 1ns/10ps
interface qhbp_bus_if;
  // mode strap, high selects strobe style
  logic bus_mode;
  // host driven pins
  logic [2:0] addr;
  logic [7:0] host_data;
  logic host_data_oe;
  logic read_strobe_n;
  logic write_strobe_n;
  logic chan_a_select_n;
  logic chan_b_select_n;
  logic chan_c_select_n;
  logic chan_d_select_n;
  // device driven pins
  logic [7:0] dev_data;
  logic dev_data_oe;
  logic chan_a_interrupt;
  logic [3:1] chan_bcd_interrupt;
  logic [3:0] irq_oe;
  // resolved data bus, host wins only when the device is silent
  logic [7:0] data_bus;
  assign data_bus = dev_data_oe ? dev_data :
                    (host_data_oe ? host_data : 8'hff);
  // shared open-drain line with external pull-up
  logic irq_line_n;
  assign irq_line_n = (irq_oe[0] && !chan_a_interrupt) ? 1'b0 : 1'b1;
  // device end
  modport dev (
    input bus_mode, addr, data_bus, read_strobe_n, write_strobe_n,
    input chan_a_select_n, chan_b_select_n, chan_c_select_n,
    input chan_d_select_n,
    output dev_data, dev_data_oe, chan_a_interrupt, chan_bcd_interrupt,
    output irq_oe
  );
  // host end
  modport host (
    output bus_mode, addr, host_data, host_data_oe, read_strobe_n,
    output write_strobe_n, chan_a_select_n, chan_b_select_n,
    output chan_c_select_n, chan_d_select_n,
    input data_bus, chan_a_interrupt, chan_bcd_interrupt, irq_oe,
    input irq_line_n
  );
endinterface

// ---- design/qhbp_host.sv ----
// host end: turns byte requests into bus cycles of either style
`timescale 1ns/10ps
module qhbp_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host bus pins
  qhbp_bus_if.host bus,
  // bus style strap, high selects strobe style
  input wire logic strobe_mode,
  // request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [1:0] req_chan,
  input wire logic [qhbp_pkg::ADDR_W-1:0] req_addr,
  input wire logic [qhbp_pkg::DATA_W-1:0] req_wdata,
  // read answer
  output logic rsp_valid,
  output logic [qhbp_pkg::DATA_W-1:0] rsp_data
);
  import qhbp_pkg::*;

  qhbp_hst_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;        // cycles left in phase
  logic write_reg, write_next;                // current cycle writes
  logic [1:0] chan_reg, chan_next;
  logic [2:0] addr_reg, addr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic [7:0] rsp_data_reg, rsp_data_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic active;                               // cycle open; select asserted in strobe style
  logic strobe;                               // strobe asserted

  // cycle sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    write_next = write_reg;
    chan_next = chan_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rsp_data_next = rsp_data_reg;
    rsp_valid_next = 1'b0;
    case (state_reg)
      QHBP_HST_IDLE: begin
        if (req_valid) begin
          // take request, drive address first; select too in strobe style, line style selects only with the strobe
          state_next = QHBP_HST_SETUP;
          cnt_next = CNT_W'(SETUP_CYC - 1);
          write_next = req_write;
          chan_next = req_chan;
          addr_next = req_addr;
          wdata_next = req_wdata;
        end
      end
      QHBP_HST_SETUP: begin
        if (cnt_reg == '0) begin
          state_next = QHBP_HST_STROBE;
          cnt_next = CNT_W'(STROBE_CYC - 1);
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      QHBP_HST_STROBE: begin
        if (cnt_reg == '0) begin
          // capture on the strobe's rising edge
          state_next = QHBP_HST_HOLD;
          cnt_next = CNT_W'(HOLD_CYC - 1);
          if (!write_reg) begin
            rsp_data_next = bus.data_bus;
            rsp_valid_next = 1'b1;
          end
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      QHBP_HST_HOLD: begin
        // data and address held past the rising edge
        if (cnt_reg == '0) begin
          state_next = QHBP_HST_IDLE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = QHBP_HST_IDLE;
      end
    endcase
  end

  // register state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= QHBP_HST_IDLE;
      cnt_reg <= '0;
      write_reg <= 1'b0;
      chan_reg <= 2'h0;
      addr_reg <= 3'h0;
      wdata_reg <= 8'h00;
      rsp_data_reg <= 8'h00;
      rsp_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      write_reg <= write_next;
      chan_reg <= chan_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rsp_data_reg <= rsp_data_next;
      rsp_valid_reg <= rsp_valid_next;
    end
  end

  // pin levels from state
  assign active = (state_reg != QHBP_HST_IDLE);
  assign strobe = (state_reg == QHBP_HST_STROBE);
  assign bus.bus_mode = strobe_mode;
  assign bus.addr = addr_reg;
  assign bus.host_data = wdata_reg;
  assign bus.host_data_oe = active && write_reg;
  // strobe style: per-channel selects and two strobes
  // line style: one select, A4/A3, direction on the write pin
  always_comb begin
    if (strobe_mode) begin
      bus.read_strobe_n = !(strobe && !write_reg);
      bus.write_strobe_n = !(strobe && write_reg);
      bus.chan_a_select_n = !(active && chan_reg == 2'h0);
      bus.chan_b_select_n = !(active && chan_reg == 2'h1);
      bus.chan_c_select_n = !(active && chan_reg == 2'h2);
      bus.chan_d_select_n = !(active && chan_reg == 2'h3);
    end else begin
      bus.read_strobe_n = 1'b1;
      bus.write_strobe_n = !write_reg;
      bus.chan_a_select_n = !strobe;
      bus.chan_b_select_n = chan_reg[0];
      bus.chan_c_select_n = chan_reg[1];
      bus.chan_d_select_n = 1'b1;
    end
  end
  assign req_ready = (state_reg == QHBP_HST_IDLE);
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
endmodule // qhbp_host

// ---- test/qhbp_sva.sv ----
// checker for the pins between the host end and the device end
`timescale 1ns/10ps
module qhbp_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host driven pins
  input wire logic bus_mode,
  input wire logic [7:0] host_data,
  input wire logic host_data_oe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic chan_c_select_n,
  input wire logic chan_d_select_n,
  // device driven pins
  input wire logic [7:0] dev_data,
  input wire logic dev_data_oe,
  input wire logic chan_a_interrupt,
  input wire logic [3:1] chan_bcd_interrupt,
  input wire logic [3:0] irq_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // some channel select low in strobe style
  wire logic any_sel;
  assign any_sel = !(chan_a_select_n && chan_b_select_n &&
                     chan_c_select_n && chan_d_select_n);
  // no access can be open on the pins
  wire logic no_sel;
  assign no_sel = bus_mode ? !any_sel : chan_a_select_n;
  // first edge of a strobe-style read
  sequence rd_open;
    bus_mode && any_sel && !read_strobe_n && $past(read_strobe_n);
  endsequence
  // first edge of a line-style read
  sequence line_rd_open;
    !bus_mode && !chan_a_select_n && $past(chan_a_select_n) &&
    write_strobe_n;
  endsequence
  // device drives a steady byte while the access lasts
  sequence rd_drive;
    dev_data_oe ##1 (dev_data_oe && $stable(dev_data))[*2];
  endsequence
  a_read_drive: assert property (rd_open |=> rd_drive)
    else $error("strobe read byte not driven steadily");
  a_line_read: assert property (line_rd_open |=> rd_drive)
    else $error("line read byte not driven steadily");
  a_read_release: assert property (
    bus_mode && $rose(read_strobe_n) |=> !dev_data_oe)
    else $error("data bus not released after read");
  a_write_quiet: assert property (
    !write_strobe_n && (bus_mode ? any_sel : !chan_a_select_n)
    |-> !dev_data_oe)
    else $error("device drives bus during write");
  a_write_hold: assert property (
    bus_mode && $rose(write_strobe_n) |-> host_data_oe && $stable(host_data))
    else $error("write data not held to strobe rise");
  a_no_select: assert property (no_sel[*2] |-> !dev_data_oe)
    else $error("device drives bus without select");
  a_line_irq: assert property (
    !bus_mode && !$past(bus_mode) && $past(rst_n) |-> !chan_a_interrupt &&
    chan_bcd_interrupt == 3'h0 && irq_oe[3:1] == 3'h7)
    else $error("line style interrupt pins wrong");
  a_line_unused: assert property (
    !bus_mode |-> read_strobe_n && chan_d_select_n)
    else $error("unused pins moved in line style");
endmodule // qhbp_sva

// ---- test/tb_quad_uart_host_bus_port.sv ----
// self-checking bench joining host end and device end
`timescale 1ns/10ps
module tb_quad_uart_host_bus_port;
  import qhbp_pkg::*;
  logic clk = 1'b0;
  logic rst_n;
  logic strobe_mode;
  logic [3:0] chan_irq;
  logic req_valid, req_ready, req_write;
  logic [1:0] req_chan;
  logic [2:0] req_addr;
  logic [7:0] req_wdata, rsp_data;
  logic rsp_valid, wr_pulse;
  logic [1:0] wr_chan;
  logic [2:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] mem [4][8];       // expected register contents
  logic [12:0] wr_q[$];         // expected write notices
  logic [7:0] rd_q[$];          // expected read answers
  int fails = 0;
  int samples_checked = 0;
  qhbp_bus_if bif ();
  qhbp_dev i_qhbp_dev (.clk(clk), .rst_n(rst_n), .bus(bif),
    .chan_irq(chan_irq), .wr_pulse(wr_pulse), .wr_chan(wr_chan),
    .wr_addr(wr_addr), .wr_data(wr_data));
  qhbp_host i_qhbp_host (.clk(clk), .rst_n(rst_n), .bus(bif),
    .strobe_mode(strobe_mode), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_chan(req_chan),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));
  qhbp_sva i_qhbp_sva (.clk(clk), .rst_n(rst_n), .bus_mode(bif.bus_mode),
    .host_data(bif.host_data), .host_data_oe(bif.host_data_oe),
    .read_strobe_n(bif.read_strobe_n), .write_strobe_n(bif.write_strobe_n),
    .chan_a_select_n(bif.chan_a_select_n),
    .chan_b_select_n(bif.chan_b_select_n),
    .chan_c_select_n(bif.chan_c_select_n),
    .chan_d_select_n(bif.chan_d_select_n), .dev_data(bif.dev_data),
    .dev_data_oe(bif.dev_data_oe), .chan_a_interrupt(bif.chan_a_interrupt),
    .chan_bcd_interrupt(bif.chan_bcd_interrupt), .irq_oe(bif.irq_oe));
  // 20 MHz clock
  always #25 clk = ~clk;
  // compare one value and count it
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // print counts and verdict, then end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // wait until the host end is idle, sampled away from the edge
  task automatic wait_ready;
    logic rdy;
    do begin
      @(negedge clk);
      rdy = req_ready;
      @(posedge clk);
    end while (rdy !== 1'b1);
  endtask
  // one byte request, expectation noted when it is made
  task automatic xfer(input logic w, input logic [1:0] c,
                      input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #5;
    req_valid = 1'b1;
    req_write = w;
    req_chan = c;
    req_addr = a;
    req_wdata = d;
    if (w) begin
      wr_q.push_back({c, a, d});
      mem[c][a] = d;
    end else begin
      rd_q.push_back(mem[c][a]);
    end
    wait_ready();
    #5 req_valid = 1'b0;
  endtask
  // interrupt pins in the current style, bus idle
  task automatic irq_chk(input logic m);
    logic [3:0] oe;
    wait_ready();
    repeat (3) @(posedge clk);
    #5 chan_irq = 4'($urandom);
    repeat (3) @(posedge clk);
    #1;
    for (int k = 0; k < 4; k++)
      oe[k] = mem[k][MODEM_CTRL_OFS][MODEM_CTRL_IRQ_EN_BIT];
    check({bif.read_strobe_n, bif.chan_a_select_n, bif.chan_d_select_n},
          13'h7);
    if (m) begin
      check(bif.irq_oe, oe);
      check({bif.chan_bcd_interrupt, bif.chan_a_interrupt}, chan_irq);
    end else begin
      check(bif.irq_oe, {3'h7, |chan_irq});
      check(bif.irq_line_n, !(|chan_irq));
      check(bif.chan_bcd_interrupt, 13'h0);
    end
    $display("interrupt test done, style %0d", m);
  endtask
  // reads and writes on every channel in one style
  task automatic run_mode(input logic m);
    logic [2:0] a;
    wait_ready();
    #5 strobe_mode = m;
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 2; k++) begin
        a = k ? MODEM_CTRL_OFS : 3'($urandom);
        xfer(1'b0, 2'(c), a, 8'h00);
        xfer(1'b1, 2'(c), a, 8'($urandom));
        xfer(1'b0, 2'(c), a, 8'h00);
      end
    end
    $display("access test done, style %0d", m);
    irq_chk(m);
  endtask
  // watcher: compare each notice and answer with the oldest note
  // sampled mid-cycle, where the registered pulses have settled
  always @(negedge clk) begin
    if (rst_n === 1'b1 && wr_pulse === 1'b1)
      check({wr_chan, wr_addr, wr_data}, wr_q.pop_front());
    if (rst_n === 1'b1 && rsp_valid === 1'b1)
      check(rsp_data, rd_q.pop_front());
  end
  // watchdog against a hang
  initial begin
    #(4000 * 50);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    strobe_mode = 1'b1;
    chan_irq = 4'h0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_chan = 2'h0;
    req_addr = 3'h0;
    req_wdata = 8'h00;
    foreach (mem[i, j]) mem[i][j] = REG_RESET;
    void'($urandom(34));
    repeat (10) @(posedge clk);
    #5 rst_n = 1'b1;
    run_mode(1'b1);
    run_mode(1'b0);
    run_mode(1'b1);
    repeat (10) @(posedge clk);
    check(13'(wr_q.size() + rd_q.size()), 13'h0);
    stop_test();
  end
endmodule // tb_quad_uart_host_bus_port
